// ---- core/rtc_pkg.sv ----
// Package of register map, field layout and timing constants for the clock core
package rtc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_HUND     = 8'h00;
  localparam logic [7:0] A_SEC      = 8'h01;
  localparam logic [7:0] A_MIN      = 8'h02;
  localparam logic [7:0] A_HOUR     = 8'h03;
  localparam logic [7:0] A_DATE     = 8'h04;
  localparam logic [7:0] A_MONTH    = 8'h05;
  localparam logic [7:0] A_YEAR     = 8'h06;
  localparam logic [7:0] A_DOW      = 8'h07;
  localparam logic [7:0] A_CTRL     = 8'h08;
  localparam logic [7:0] A_STATUS   = 8'h09;
  localparam logic [7:0] A_TMR_LOAD = 8'h0a;
  localparam logic [7:0] A_TMR_CTRL = 8'h0b;
  localparam logic [7:0] A_TMR_CNT  = 8'h0c;
  localparam logic [7:0] A_ALM_BASE = 8'h10;
  localparam logic [7:0] A_ALM_LAST = 8'h15;
  localparam int         ALM_N      = 6;
  localparam logic [7:0] ALM_EN_MASK = 8'h80;
  localparam logic [7:0] ALM_VAL_MASK = 8'h7f;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_ALM_EN   = 0;
  localparam int CTL_REPEAT   = 1;
  localparam int CTL_FSEL_LO  = 2;
  localparam int CTL_FSEL_HI  = 3;
  localparam int CTL_FUNC1    = 4;
  localparam int CTL_SEL2_ALM = 5;
  localparam int CTL_SEL2_TMR = 6;
  localparam int CTL_IRQ1_EN  = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Status bits
  localparam int ST_ALM  = 0;
  localparam int ST_TMR  = 1;
  localparam int ST_HALT = 2;

  // Timer control bits
  localparam int TC_EN     = 0;
  localparam int TC_CLK_LO = 1;
  localparam int TC_CLK_HI = 2;

  // ----------------------------------------------------------------
  // Field limits and calendar
  // ----------------------------------------------------------------
  localparam logic [7:0] V0      = 8'h00;
  localparam logic [7:0] V1      = 8'h01;
  localparam logic [7:0] HUND_HI = 8'h63;
  localparam logic [7:0] SEC_HI  = 8'h3b;
  localparam logic [7:0] HOUR_HI = 8'h17;
  localparam logic [7:0] YEAR_HI = 8'h63;
  localparam logic [7:0] MON_HI  = 8'h0c;
  localparam logic [7:0] DOW_HI  = 8'h06;
  localparam logic [7:0] FEB     = 8'h02;
  localparam logic [7:0] APR     = 8'h04;
  localparam logic [7:0] JUN     = 8'h06;
  localparam logic [7:0] SEP     = 8'h09;
  localparam logic [7:0] NOV     = 8'h0b;
  localparam logic [7:0] D28     = 8'h1c;
  localparam logic [7:0] D29     = 8'h1d;
  localparam logic [7:0] D30     = 8'h1e;
  localparam logic [7:0] D31     = 8'h1f;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam logic [16:0] XTAL_HZ   = 17'h08000;
  localparam logic [16:0] HUND_STEP = 17'h00064;
  localparam int          PRE_W     = 15;
  localparam int          F4096_BIT = 2;
  localparam int          F1024_BIT = 4;
  localparam int          F1_BIT    = 14;
endpackage : rtc_pkg

// ---- core/rtc_fld_if.sv ----
// Interface joining one time or calendar field counter to the core
`timescale 1ns/10ps
`default_nettype none
interface rtc_fld_if #(parameter int W = 8);
  logic         inc;
  logic         wr;
  logic [W-1:0] wdata;
  logic [W-1:0] lo;
  logic [W-1:0] hi;
  logic [W-1:0] value;
  logic         carry;
  modport ctl (output inc, output wr, output wdata, output lo, output hi, input value, input carry);
  modport cnt (input inc, input wr, input wdata, input lo, input hi, output value, output carry);
endinterface : rtc_fld_if
`default_nettype wire

// ---- core/rtc_field_counter.sv ----
// One wrapping time or calendar field counter
`timescale 1ns/10ps
`default_nettype none
module rtc_field_counter #(
  parameter int         W   = 8,
  parameter logic [7:0] RST = 8'h00
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  rtc_fld_if.cnt   f
);
  logic [W-1:0] value_q;
  logic [W-1:0] value_d;

  assign f.carry = f.inc && (value_q == f.hi);
  assign f.value = value_q;
  assign value_d = f.wr ? f.wdata : (f.carry ? f.lo : value_q + 1'b1);

  // Host write wins over a tick in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      value_q <= RST[W-1:0];
    end else if (f.wr || f.inc) begin
      value_q <= value_d;
    end
  end
endmodule : rtc_field_counter
`default_nettype wire

// ---- core/rtc_alarm_timer_irq_core.sv ----
// Clock, calendar, alarm, timer and interrupt pin core
// Functional notes
// R1: Sub-second, second, minute and hour counters each read back as their own register.
// R2: Date, month, year and day of week each live in their own register.
// R3: The calendar rolls over through 2099 and adds 29 February in every fourth year by itself.
// R4: The alarm fires when all enabled alarm fields match the running time, any of second, minute, hour, date, month and day of week being usable.
// R5: An alarm sets a status flag and, when configured, pulls the first or the second pin low.
// R6: In repeat mode the alarm fires again at every match, its period set by which fields are enabled.
// R7: Timer expiry sets a status flag and, when configured, pulls only the second pin low.
// R8: Timekeeping advances from the crystal-rate timebase on the crystal input, crystal or external source.
// R9: The first pin is open drain, only ever pulled low or released.
// R10: A control field chooses interrupt or frequency output for the first pin, and the pin follows it.
// R11: In interrupt mode the first pin asserts while an alarm is pending; the code asserts it only when CTL_IRQ1_EN is also set.
// R12: In frequency mode the first pin carries a host-selected division of the crystal clock.
// R13: A control field chooses whether alarm or timer events go to the second pin.
// R14: The alarm is disabled while frequency output is enabled.
// R15: After reset the clock stays halted until the host writes a clock register.
// R16: Alarm and timer flags stay set until the host clears them.
// R17: An interrupt pin in interrupt mode is released while nothing enabled for it is pending.
`timescale 1ns/10ps
`default_nettype none
module rtc_alarm_timer_irq_core
  import rtc_pkg::*;
#(
  parameter int FW = 8
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       crystal_input,
  output logic            crystal_output,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            first_irq_or_freq_pin_o,
  output logic            first_irq_or_freq_pin_oe,
  output logic            second_irq_pin_o,
  output logic            second_irq_pin_oe
);
  // ----------------------------------------------------------------
  // Timebase input synchroniser
  // ----------------------------------------------------------------
  logic             xs1_q;
  logic             xs2_q;
  logic             xs3_q;
  logic             xlvl_q;
  logic             xtal_tick;
  logic [PRE_W-1:0] pre_q;

  assign crystal_output = ~xlvl_q;
  assign xtal_tick      = (xs2_q == xs3_q) && xs2_q && !xlvl_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      xs1_q  <= 1'b0;
      xs2_q  <= 1'b0;
      xs3_q  <= 1'b0;
      xlvl_q <= 1'b0;
    end else begin
      xs1_q <= crystal_input;
      xs2_q <= xs1_q;
      xs3_q <= xs2_q;
      if (xs2_q == xs3_q) begin
        xlvl_q <= xs2_q;
      end
    end
  end

  // Crystal prescaler feeding the frequency output
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pre_q <= '0;
    end else if (xtal_tick) begin
      pre_q <= pre_q + 1'b1; // see R8
    end
  end

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  logic       wr_hund, wr_sec, wr_min, wr_hour;
  logic       wr_date, wr_mon, wr_year, wr_dow;
  logic       wr_ctrl, wr_stat, wr_tload, wr_tctrl;
  logic       wr_time;
  logic       wr_alm;
  logic [7:0] alm_idx;

  assign wr_hund  = reg_wr && (reg_addr == A_HUND);
  assign wr_sec   = reg_wr && (reg_addr == A_SEC);
  assign wr_min   = reg_wr && (reg_addr == A_MIN);
  assign wr_hour  = reg_wr && (reg_addr == A_HOUR);
  assign wr_date  = reg_wr && (reg_addr == A_DATE);
  assign wr_mon   = reg_wr && (reg_addr == A_MONTH);
  assign wr_year  = reg_wr && (reg_addr == A_YEAR);
  assign wr_dow   = reg_wr && (reg_addr == A_DOW);
  assign wr_ctrl  = reg_wr && (reg_addr == A_CTRL);
  assign wr_stat  = reg_wr && (reg_addr == A_STATUS);
  assign wr_tload = reg_wr && (reg_addr == A_TMR_LOAD);
  assign wr_tctrl = reg_wr && (reg_addr == A_TMR_CTRL);
  assign wr_time  = reg_wr && (reg_addr <= A_DOW);
  assign wr_alm   = reg_wr && (reg_addr >= A_ALM_BASE) && (reg_addr <= A_ALM_LAST);
  assign alm_idx  = reg_addr - A_ALM_BASE;

  // ----------------------------------------------------------------
  // Run control and sub-second divider
  // ----------------------------------------------------------------
  logic        run_q;
  logic [16:0] frac_q;
  logic [16:0] frac_sum;
  logic        hund_tick;

  assign frac_sum  = frac_q + HUND_STEP;
  assign hund_tick = run_q && xtal_tick && (frac_sum >= XTAL_HZ);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      run_q  <= 1'b0;
      frac_q <= '0;
    end else begin
      if (wr_time) begin
        run_q <= 1'b1; // see R15
      end
      if (wr_hund) begin
        frac_q <= '0;
      end else if (run_q && xtal_tick) begin
        frac_q <= hund_tick ? frac_sum - XTAL_HZ : frac_sum; // see R8
      end
    end
  end

  // ----------------------------------------------------------------
  // Time and calendar fields
  // ----------------------------------------------------------------
  rtc_fld_if #(.W(FW)) f_hund ();
  rtc_fld_if #(.W(FW)) f_sec ();
  rtc_fld_if #(.W(FW)) f_min ();
  rtc_fld_if #(.W(FW)) f_hour ();
  rtc_fld_if #(.W(FW)) f_date ();
  rtc_fld_if #(.W(FW)) f_mon ();
  rtc_fld_if #(.W(FW)) f_year ();
  rtc_fld_if #(.W(FW)) f_dow ();

  logic       leap;
  logic [7:0] mdays;

  assign leap  = (f_year.value[1:0] == 2'b00); // see R3
  assign mdays = (f_mon.value == FEB) ? (leap ? D29 : D28) :
                 ((f_mon.value == APR) || (f_mon.value == JUN) ||
                  (f_mon.value == SEP) || (f_mon.value == NOV)) ? D30 : D31; // see R3

  // Carry chain through every field
  assign f_hund.inc = hund_tick; // see R1
  assign f_sec.inc  = f_hund.carry;
  assign f_min.inc  = f_sec.carry;
  assign f_hour.inc = f_min.carry;
  assign f_date.inc = f_hour.carry; // see R2
  assign f_dow.inc  = f_hour.carry;
  assign f_mon.inc  = f_date.carry;
  assign f_year.inc = f_mon.carry; // see R3

  assign f_hund.lo = V0;
  assign f_hund.hi = HUND_HI;
  assign f_sec.lo  = V0;
  assign f_sec.hi  = SEC_HI;
  assign f_min.lo  = V0;
  assign f_min.hi  = SEC_HI;
  assign f_hour.lo = V0;
  assign f_hour.hi = HOUR_HI;
  assign f_date.lo = V1;
  assign f_date.hi = mdays;
  assign f_mon.lo  = V1;
  assign f_mon.hi  = MON_HI;
  assign f_year.lo = V0;
  assign f_year.hi = YEAR_HI;
  assign f_dow.lo  = V0;
  assign f_dow.hi  = DOW_HI;

  assign f_hund.wr = wr_hund;
  assign f_sec.wr  = wr_sec;
  assign f_min.wr  = wr_min;
  assign f_hour.wr = wr_hour;
  assign f_date.wr = wr_date;
  assign f_mon.wr  = wr_mon;
  assign f_year.wr = wr_year;
  assign f_dow.wr  = wr_dow;

  assign f_hund.wdata = reg_wdata;
  assign f_sec.wdata  = reg_wdata;
  assign f_min.wdata  = reg_wdata;
  assign f_hour.wdata = reg_wdata;
  assign f_date.wdata = reg_wdata;
  assign f_mon.wdata  = reg_wdata;
  assign f_year.wdata = reg_wdata;
  assign f_dow.wdata  = reg_wdata;

  rtc_field_counter #(.W(FW), .RST(V0)) u_hund (.clk_sys(clk_sys), .rst_b(rst_b), .f(f_hund));
  rtc_field_counter #(.W(FW), .RST(V0)) u_sec  (.clk_sys(clk_sys), .rst_b(rst_b), .f(f_sec));
  rtc_field_counter #(.W(FW), .RST(V0)) u_min  (.clk_sys(clk_sys), .rst_b(rst_b), .f(f_min));
  rtc_field_counter #(.W(FW), .RST(V0)) u_hour (.clk_sys(clk_sys), .rst_b(rst_b), .f(f_hour));
  rtc_field_counter #(.W(FW), .RST(V1)) u_date (.clk_sys(clk_sys), .rst_b(rst_b), .f(f_date));
  rtc_field_counter #(.W(FW), .RST(V1)) u_mon  (.clk_sys(clk_sys), .rst_b(rst_b), .f(f_mon));
  rtc_field_counter #(.W(FW), .RST(V0)) u_year (.clk_sys(clk_sys), .rst_b(rst_b), .f(f_year));
  rtc_field_counter #(.W(FW), .RST(V0)) u_dow  (.clk_sys(clk_sys), .rst_b(rst_b), .f(f_dow));

  // ----------------------------------------------------------------
  // Control, alarm and timer registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] alm_q [ALM_N];
  logic [7:0] tload_q;
  logic [7:0] tctrl_q;
  logic [7:0] tcnt_q;
  logic       sec_evt_q;
  logic       alm_done_q;
  logic       alm_flag_q;
  logic       tmr_flag_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_q  <= CTRL_RST;
      tload_q <= '0;
      tctrl_q <= '0;
      for (int i = 0; i < ALM_N; i++) begin
        alm_q[i] <= '0;
      end
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata; // see R10
      end
      if (wr_tload) begin
        tload_q <= reg_wdata;
      end
      if (wr_tctrl) begin
        tctrl_q <= reg_wdata;
      end
      if (wr_alm) begin
        alm_q[alm_idx[2:0]] <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm compare
  // ----------------------------------------------------------------
  logic [ALM_N-1:0] fld_en;
  logic [ALM_N-1:0] fld_ok;
  logic [7:0]       cur [ALM_N];
  logic             alm_active;
  logic             alm_match;
  logic             alm_hit;

  assign cur[0] = f_sec.value;
  assign cur[1] = f_min.value;
  assign cur[2] = f_hour.value;
  assign cur[3] = f_date.value;
  assign cur[4] = f_mon.value;
  assign cur[5] = f_dow.value;

  for (genvar g = 0; g < ALM_N; g++) begin : g_cmp
    assign fld_en[g] = |(alm_q[g] & ALM_EN_MASK);
    assign fld_ok[g] = !fld_en[g] || ((alm_q[g] & ALM_VAL_MASK) == cur[g]); // see R4
  end

  assign alm_active = ctrl_q[CTL_ALM_EN] && !ctrl_q[CTL_FUNC1]; // see R14
  assign alm_match  = (&fld_ok) && (|fld_en);
  // Compared once per second, after the counters have settled
  assign alm_hit    = sec_evt_q && alm_active && alm_match &&
                      (ctrl_q[CTL_REPEAT] || !alm_done_q); // see R6

  // ----------------------------------------------------------------
  // Timer
  // ----------------------------------------------------------------
  logic [3:0] tsrc;
  logic       tmr_tick;
  logic       tmr_exp;

  // A field's carry marks the tick of the next field up
  assign tsrc     = {f_min.carry, f_sec.carry, f_hund.carry, hund_tick};
  assign tmr_tick = tctrl_q[TC_EN] && tsrc[tctrl_q[TC_CLK_HI:TC_CLK_LO]];
  assign tmr_exp  = tmr_tick && (tcnt_q <= V1); // see R7

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tcnt_q <= '0;
    end else if (wr_tload || tmr_exp) begin
      tcnt_q <= wr_tload ? reg_wdata : tload_q;
    end else if (tmr_tick) begin
      tcnt_q <= tcnt_q - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Status flags, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sec_evt_q  <= 1'b0;
      alm_done_q <= 1'b0;
      alm_flag_q <= 1'b0;
      tmr_flag_q <= 1'b0;
    end else begin
      sec_evt_q <= f_hund.carry;
      if (alm_hit) begin
        alm_done_q <= 1'b1;
      end else if (wr_ctrl) begin
        alm_done_q <= 1'b0;
      end
      if (alm_hit) begin
        alm_flag_q <= 1'b1; // see R5
      end else if (wr_stat && reg_wdata[ST_ALM]) begin
        alm_flag_q <= 1'b0; // see R16
      end
      if (tmr_exp) begin
        tmr_flag_q <= 1'b1; // see R7
      end else if (wr_stat && reg_wdata[ST_TMR]) begin
        tmr_flag_q <= 1'b0; // see R16
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and frequency pins
  // ----------------------------------------------------------------
  logic [3:0] fsrc;
  logic       fout_lvl;
  logic       irq1_pend;
  logic       second_irq_pin_pend;

  assign fsrc     = {pre_q[F1_BIT], pre_q[F1024_BIT], pre_q[F4096_BIT], xlvl_q};
  assign fout_lvl = fsrc[ctrl_q[CTL_FSEL_HI:CTL_FSEL_LO]]; // see R12
  assign irq1_pend = ctrl_q[CTL_IRQ1_EN] && alm_flag_q; // see R11
  assign second_irq_pin_pend = (ctrl_q[CTL_SEL2_ALM] && alm_flag_q) ||
                     (ctrl_q[CTL_SEL2_TMR] && tmr_flag_q); // see R13

  // Open drain: the data output is always low, only the enable moves
  assign first_irq_or_freq_pin_o  = 1'b0; // see R9
  assign first_irq_or_freq_pin_oe = ctrl_q[CTL_FUNC1] ? !fout_lvl : irq1_pend; // see R10
  assign second_irq_pin_o         = 1'b0;
  assign second_irq_pin_oe        = second_irq_pin_pend; // see R17

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] status;

  assign status = {5'h00, !run_q, tmr_flag_q, alm_flag_q};

  always_comb begin
    rd_mux = '0;
    if (reg_addr == A_HUND) begin
      rd_mux = f_hund.value;
    end else if (reg_addr == A_SEC) begin
      rd_mux = f_sec.value;
    end else if (reg_addr == A_MIN) begin
      rd_mux = f_min.value;
    end else if (reg_addr == A_HOUR) begin
      rd_mux = f_hour.value;
    end else if (reg_addr == A_DATE) begin
      rd_mux = f_date.value;
    end else if (reg_addr == A_MONTH) begin
      rd_mux = f_mon.value;
    end else if (reg_addr == A_YEAR) begin
      rd_mux = f_year.value;
    end else if (reg_addr == A_DOW) begin
      rd_mux = f_dow.value;
    end else if (reg_addr == A_CTRL) begin
      rd_mux = ctrl_q;
    end else if (reg_addr == A_STATUS) begin
      rd_mux = status;
    end else if (reg_addr == A_TMR_LOAD) begin
      rd_mux = tload_q;
    end else if (reg_addr == A_TMR_CTRL) begin
      rd_mux = tctrl_q;
    end else if (reg_addr == A_TMR_CNT) begin
      rd_mux = tcnt_q;
    end else if ((reg_addr >= A_ALM_BASE) && (reg_addr <= A_ALM_LAST)) begin
      rd_mux = alm_q[alm_idx[2:0]];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux; // see R1
    end
  end
endmodule : rtc_alarm_timer_irq_core
`default_nettype wire

// ---- test/rtc_core_props.sv ----
// Port-level checker for the clock core
`timescale 1ns/10ps
`default_nettype none
module rtc_core_props
  import rtc_pkg::*;
#(
  parameter int FW = 8
) (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       first_irq_or_freq_pin_o,
  input wire logic       first_irq_or_freq_pin_oe,
  input wire logic       second_irq_pin_o,
  input wire logic       second_irq_pin_oe
);
  logic [7:0] ctl_q;
  logic       set_q;
  wire        ctl_wr = reg_wr && reg_addr == A_CTRL;
  wire        unmap  = (reg_addr > A_TMR_CNT && reg_addr < A_ALM_BASE) || reg_addr > A_ALM_LAST;

  // ----------------------------------------------------------------
  // Shadow of control and of the first clock write
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctl_q <= CTRL_RST;
      set_q <= 1'b0;
    end else begin
      if (ctl_wr) begin
        ctl_q <= reg_wdata;
      end
      if (reg_wr && reg_addr <= A_DOW) begin
        set_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  pins_drain_a : assert property (!first_irq_or_freq_pin_o && !second_irq_pin_o)
    else $error("open drain pin driven high");
  reset_quiet_a : assert property (disable iff (1'b0) !rst_b |=> !first_irq_or_freq_pin_oe && !second_irq_pin_oe && reg_rdata == V0)
    else $error("outputs active after reset");
  unmap_zero_a : assert property (reg_rd && unmap |=> reg_rdata == V0)
    else $error("unmapped read not zero");
  ctrl_back_a : assert property (reg_rd && reg_addr == A_CTRL |=> reg_rdata == $past(ctl_q))
    else $error("control readback wrong");
  halt_bit_a : assert property (reg_rd && reg_addr == A_STATUS && !set_q |=> reg_rdata[ST_HALT])
    else $error("clock not halted before first write");
  pin2_idle_a : assert property (ctl_q[CTL_SEL2_TMR:CTL_SEL2_ALM] == 2'b00 |-> !second_irq_pin_oe)
    else $error("second pin low with no source");
  pin1_idle_a : assert property (!ctl_q[CTL_FUNC1] && !ctl_q[CTL_IRQ1_EN] |-> !first_irq_or_freq_pin_oe)
    else $error("first pin low while disabled");
  flag_hold_a : assert property (second_irq_pin_oe && !reg_wr |=> second_irq_pin_oe)
    else $error("pending event dropped without clear");
  pin_pair_a : assert property (ctl_q[7:4] == 4'ha |-> first_irq_or_freq_pin_oe == second_irq_pin_oe)
    else $error("alarm pins disagree");
  freq_noalm_a : assert property (ctl_q[6:4] == 3'b011 && !second_irq_pin_oe && !reg_wr |=> !second_irq_pin_oe)
    else $error("alarm fired in frequency mode");
endmodule : rtc_core_props

bind rtc_alarm_timer_irq_core rtc_core_props #(.FW(FW)) u_props (.clk_sys, .rst_b, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .first_irq_or_freq_pin_o, .first_irq_or_freq_pin_oe, .second_irq_pin_o,
  .second_irq_pin_oe);
`default_nettype wire

// ---- test/rtc_pin_model.sv ----
// Timebase source and pull-ups on the two open-drain pins
`timescale 1ns/10ps
`default_nettype none
module rtc_pin_model #(
  parameter int HALF_NS = 40
) (
  output logic      crystal_input,
  input  wire logic o1,
  input  wire logic oe1,
  input  wire logic o2,
  input  wire logic oe2,
  output wire logic pin1,
  output wire logic pin2
);
  // Runs fast so a hundredth passes in a few thousand cycles
  initial begin
    crystal_input = 1'b0;
    forever #(HALF_NS) crystal_input = ~crystal_input;
  end
  assign pin1 = oe1 ? o1 : 1'b1;
  assign pin2 = oe2 ? o2 : 1'b1;
endmodule : rtc_pin_model
`default_nettype wire

// ---- test/tb_rtc_alarm_timer_irq_core.sv ----
// Self-checking bench of the clock core
`timescale 1ns/10ps
`default_nettype none
module tb_rtc_alarm_timer_irq_core
  import rtc_pkg::*;
;
  logic       clk_sys;
  logic       rst_b;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  wire logic  xtal;
  wire logic  xout;
  int         nx;
  int         sh;
  logic       px;
  wire logic  o1, oe1, o2, oe2, pin1, pin2;
  int         miscompares = 0;
  int         checks = 0;
  int         n;
  logic       p;
  // Start date, month, year, then date, month, year after midnight
  logic [7:0] cal [5][6] = '{'{8'h1f, 8'h0c, 8'h62, 8'h01, 8'h01, 8'h63},
                             '{8'h1c, 8'h02, 8'h04, 8'h1d, 8'h02, 8'h04},
                             '{8'h1c, 8'h02, 8'h05, 8'h01, 8'h03, 8'h05},
                             '{8'h1d, 8'h02, 8'h04, 8'h01, 8'h03, 8'h04},
                             '{8'h1e, 8'h04, 8'h05, 8'h01, 8'h05, 8'h05}};

  rtc_alarm_timer_irq_core dut (.clk_sys(clk_sys), .rst_b(rst_b), .crystal_input(xtal), .crystal_output(xout),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .first_irq_or_freq_pin_o(o1), .first_irq_or_freq_pin_oe(oe1), .second_irq_pin_o(o2),
    .second_irq_pin_oe(oe2));
  rtc_pin_model u_far (.crystal_input(xtal), .o1(o1), .oe1(oe1), .o2(o2), .oe2(oe2), .pin1(pin1), .pin2(pin2));

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : idle
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    idle(1);
    reg_wr = 1'b0;
    idle(1);
  endtask : wr
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    idle(1);
    reg_rd = 1'b0;
    cmp(reg_rdata, e);
    idle(1);
  endtask : chk
  task automatic pins(input logic e1, input logic e2);
    cmp({6'h00, pin1, pin2}, {6'h00, e1, e2});
  endtask : pins
  // Sets 23:59:59.99 on the given day so the next hundredth rolls everything
  task automatic set_time(input logic [7:0] d, input logic [7:0] m, input logic [7:0] y);
    wr(A_HOUR, HOUR_HI);
    wr(A_MIN, SEC_HI);
    wr(A_SEC, SEC_HI);
    wr(A_DATE, d);
    wr(A_MONTH, m);
    wr(A_YEAR, y);
    wr(A_DOW, DOW_HI);
    wr(A_HUND, HUND_HI);
    idle(3500);
  endtask : set_time
  task automatic wrap_up();
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    reg_addr = V0;
    reg_wdata = V0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    idle(5);
    rst_b = 1'b1;
    chk(A_STATUS, 8'h04);
    chk(A_CTRL, CTRL_RST);
    chk(A_DATE, V1);
    chk(A_MONTH, V1);
    wr(8'h0e, 8'h5a);
    chk(8'h0e, V0);
    for (int i = 0; i < 5; i++) begin
      set_time(cal[i][0], cal[i][1], cal[i][2]);
      chk(A_HUND, V0);
      chk(A_SEC, V0);
      chk(A_MIN, V0);
      chk(A_HOUR, V0);
      chk(A_DATE, cal[i][3]);
      chk(A_MONTH, cal[i][4]);
      chk(A_YEAR, cal[i][5]);
      chk(A_DOW, V0);
    end
    chk(A_STATUS, V0);
    wr(A_ALM_BASE, ALM_EN_MASK);
    wr(A_CTRL, 8'ha3);
    // Second pass only fires when repeat mode works
    for (int k = 0; k < 2; k++) begin
      set_time(V1, V1, V0);
      chk(A_STATUS, 8'h01);
      pins(1'b0, 1'b0);
      wr(A_STATUS, 8'h01);
      chk(A_STATUS, V0);
      pins(1'b1, 1'b1);
    end
    // Single mode fires once after a control write, then stays quiet
    wr(A_CTRL, 8'ha1);
    set_time(V1, V1, V0);
    chk(A_STATUS, 8'h01);
    wr(A_STATUS, 8'h01);
    set_time(V1, V1, V0);
    chk(A_STATUS, V0);
    wr(A_CTRL, 8'hc0);
    wr(A_TMR_LOAD, 8'h02);
    wr(A_TMR_CTRL, 8'h01);
    idle(6000);
    chk(A_STATUS, 8'h02);
    pins(1'b1, 1'b0);
    wr(A_TMR_CTRL, V0);
    wr(A_STATUS, 8'h02);
    for (int f = 0; f < 3; f++) begin
      wr(A_CTRL, {4'h3, f[1:0], 2'b01});
      n = 0;
      p = pin1;
      nx = 0;
      px = xout;
      // Divide by 1, 8 and 32 of the crystal rate
      sh = (f == 0) ? 0 : f * 2 + 1;
      repeat (512) begin
        idle(1);
        n += int'(pin1 !== p);
        p = pin1;
        nx += int'(xout !== px);
        px = xout;
      end
      cmp((n > (128 >> sh) + 1 || n + 1 < (128 >> sh)) ? 8'hff : 8'h00, V0);
      cmp((nx > 129 || nx < 127) ? 8'hff : 8'h00, V0);
    end
    set_time(V1, V1, V0);
    chk(A_STATUS, V0);
    cmp({7'h00, pin2}, V1);
    wr(A_CTRL, V0);
    pins(1'b1, 1'b1);
    wrap_up();
  end
endmodule : tb_rtc_alarm_timer_irq_core
`default_nettype wire
